// >>> src/pxr_bank.sv
`timescale 1ns/10ps
// extended register bank, reached over the management register port
module pxr_bank
    import pxr_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic rst_b, // hardware reset, active low
    input wire logic soft_rst, // software reset pulse
    input wire logic [4:0] page_sel, // page-select register value
    input wire logic [4:0] reg_addr, // management register number
    input wire logic reg_wr, // write strobe, one cycle
    input wire logic reg_rd, // read strobe, one cycle
    input wire logic [15:0] reg_wdata, // write data
    output logic [15:0] reg_rdata_r, // read data, valid cycle after rd
    input wire logic crc_good_pkt, // one pulse per good-crc packet
    input wire logic neg_fail_1g, // one pulse per failed gigabit attempt
    input wire logic link_up_1g, // gigabit link established
    input wire logic rx_clk_in, // internal receive clock
    output logic rx_clk_out_r, // receive clock to mac
    output logic [1:0] mac_term_sel_r, // termination target
    output logic [1:0] sleep_sel_r, // sleep timer select
    output logic [1:0] lto_sel_r, // link timeout select
    output logic downshift_r, // fall back from gigabit
    output logic eeprom_reload_r, // reload eeprom pulse
    output pxr_ee_cmd_t ee_cmd_r, // request to eeprom agent
    input wire logic ee_done, // agent finished access
    input wire logic [7:0] ee_rdata, // byte from agent
    input wire logic [1:0] cal_strap, // strap_configured_default for termination
    input wire logic ds_en_strap // strap_configured_default for downshift
);
    logic ext_sel;
    logic wr_hit;
    logic rd_hit;
    logic strap_done_r;
    logic [13:0] crc_cnt_r;
    logic crc_flag_r;
    logic [1:0] cal_r;
    logic [1:0] sleep_r;
    logic [1:0] lto_r;
    logic rxclk_off_r;
    logic ds_en_r;
    logic [1:0] ds_cnt_r;
    logic ds_stat_r;
    logic [2:0] fail_cnt_r;
    logic reload_r;
    logic dir_r;
    logic [10:0] ee_addr_r;
    logic [7:0] ee_wdata_r;
    logic go_r;
    logic ee_ready;
    logic ee_idle;
    logic [2:0] fail_lim;
    logic [7:0] ee_rbyte;
    pxr_ee_cmd_t cmd;
    logic [15:0] rd_nxt;

    // only page one maps the extended set onto registers 18 to 22
    assign ext_sel = (page_sel == PXR_PAGE_EXT);
    assign wr_hit = reg_wr && ext_sel;
    assign rd_hit = reg_rd && ext_sel;

    // straps are sampled once after release, never under the async reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            strap_done_r <= 1'b0;
        end else begin
            strap_done_r <= 1'b1;
        end
    end

    // good-crc count; a packet arriving during the clearing read is kept, not lost
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            crc_cnt_r <= '0;
        end else if (rd_hit && reg_addr == PXR_OFS_CRC) begin
            crc_cnt_r <= {13'h0, crc_good_pkt};
        end else if (crc_good_pkt) begin
            crc_cnt_r <= crc_cnt_r + 14'h1;
        end
    end

    // packet-since-read flag; a packet in the clearing cycle wins over the clear
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            crc_flag_r <= 1'b0;
        end else if (rd_hit && reg_addr == PXR_OFS_CRC) begin
            crc_flag_r <= crc_good_pkt;
        end else if (crc_good_pkt) begin
            crc_flag_r <= 1'b1;
        end
    end

    // termination select: strap value at start-up, then software; hardware reset only
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cal_r <= '0;
        end else if (!strap_done_r) begin
            cal_r <= cal_strap;
        end else if (wr_hit && reg_addr == PXR_OFS_CAL) begin
            cal_r <= reg_wdata[PXR_CAL_POS +: 2];
        end
    end

    // downshift enable: strap value at start-up, then software; hardware reset only
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ds_en_r <= 1'b0;
        end else if (!strap_done_r) begin
            ds_en_r <= ds_en_strap;
        end else if (wr_hit && reg_addr == PXR_OFS_PSL) begin
            ds_en_r <= reg_wdata[PXR_DS_EN_BIT];
        end
    end

    // sleep timer and downshift threshold; a software reset leaves them
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sleep_r <= PXR_SLEEP_RST;
            ds_cnt_r <= PXR_DS_CNT_RST;
        end else if (strap_done_r && wr_hit && reg_addr == PXR_OFS_PSL) begin
            sleep_r <= reg_wdata[PXR_SLEEP_POS +: 2];
            ds_cnt_r <= reg_wdata[PXR_DS_CNT_POS +: 2];
        end
    end

    // reload request survives software reset, so the reload it asks for can follow
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reload_r <= 1'b0;
        end else if (strap_done_r && wr_hit && reg_addr == PXR_OFS_EEC) begin
            reload_r <= reg_wdata[PXR_RELOAD_BIT];
        end
    end

    // link timeout and receive clock gate: back to defaults on software reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lto_r <= PXR_LTO_RST;
            rxclk_off_r <= 1'b0;
        end else if (soft_rst) begin
            lto_r <= PXR_LTO_RST;
            rxclk_off_r <= 1'b0;
        end else if (wr_hit && reg_addr == PXR_OFS_PSL) begin
            lto_r <= reg_wdata[PXR_LTO_POS +: 2];
            rxclk_off_r <= reg_wdata[PXR_RXCLK_OFF_BIT];
        end
    end

    // writes to address and direction take effect only while idle, protecting a live access
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dir_r <= PXR_DIR_RST;
            ee_addr_r <= '0;
        end else if (soft_rst) begin
            dir_r <= PXR_DIR_RST;
            ee_addr_r <= '0;
        end else if (wr_hit && reg_addr == PXR_OFS_EEC && ee_idle) begin
            dir_r <= reg_wdata[PXR_DIR_BIT];
            ee_addr_r <= reg_wdata[10:0];
        end
    end

    // byte to store; the command already holds its copy, so a late write hits the next
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ee_wdata_r <= '0;
        end else if (soft_rst) begin
            ee_wdata_r <= '0;
        end else if (wr_hit && reg_addr == PXR_OFS_EED) begin
            ee_wdata_r <= reg_wdata[7:0];
        end
    end

    // ready drops in the cycle of the trigger itself, not one cycle late, so a
    // second trigger or an address write right behind the first is refused
    assign ee_idle = ee_ready && !go_r;

    // access trigger: single-cycle, ignored while busy
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            go_r <= 1'b0;
        end else begin
            go_r <= wr_hit && !soft_rst && reg_addr == PXR_OFS_EEC
                && reg_wdata[PXR_GO_BIT] && ee_idle;
        end
    end

    // command uses the direction written in the same write as the trigger
    assign cmd = '{req: go_r, rd: dir_r, addr: ee_addr_r, wdata: ee_wdata_r};

    pxr_ee_port u_ee (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .cmd(cmd),
        .ready_r(ee_ready),
        .rdata_r(ee_rbyte),
        .ee_cmd_r(ee_cmd_r),
        .ee_done(ee_done),
        .ee_rdata(ee_rdata)
    );

    // failed-attempt count; a gigabit link or either reset starts it again
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fail_cnt_r <= '0;
        end else if (soft_rst || link_up_1g) begin
            fail_cnt_r <= '0;
        end else if (neg_fail_1g && ds_en_r && !ds_stat_r) begin
            fail_cnt_r <= fail_cnt_r + 3'h1;
        end
    end

    // threshold is code plus two attempts; the count stops once status is set,
    // so three bits never overflow
    assign fail_lim = {1'b0, ds_cnt_r} + {1'b0, PXR_DS_BASE};

    // downshift status stays set until a hardware or software reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ds_stat_r <= 1'b0;
        end else if (soft_rst) begin
            ds_stat_r <= 1'b0;
        end else if (!link_up_1g && neg_fail_1g && ds_en_r && fail_cnt_r + 3'h1 >= fail_lim) begin
            ds_stat_r <= 1'b1;
        end
    end

    // read mux; reserved bits read zero
    always_comb begin
        rd_nxt = '0;
        unique case (reg_addr)
            PXR_OFS_CRC: rd_nxt = {crc_flag_r, 1'b0, crc_cnt_r};
            PXR_OFS_CAL: rd_nxt[PXR_CAL_POS +: 2] = cal_r;
            PXR_OFS_PSL: begin
                rd_nxt[PXR_SLEEP_POS +: 2] = sleep_r;
                rd_nxt[PXR_LTO_POS +: 2] = lto_r;
                rd_nxt[PXR_RXCLK_OFF_BIT] = rxclk_off_r;
                rd_nxt[PXR_DS_EN_BIT] = ds_en_r;
                rd_nxt[PXR_DS_CNT_POS +: 2] = ds_cnt_r;
                rd_nxt[PXR_DS_STAT_BIT] = ds_stat_r;
            end
            PXR_OFS_EEC: begin
                rd_nxt[PXR_RELOAD_BIT] = reload_r;
                rd_nxt[PXR_DIR_BIT] = dir_r;
                // the trigger bit always reads zero: it clears itself
                rd_nxt[PXR_RDY_BIT] = ee_idle;
                rd_nxt[10:0] = ee_addr_r;
            end
            PXR_OFS_EED: rd_nxt = {ee_rbyte, ee_wdata_r};
            default: rd_nxt = '0;
        endcase
    end

    // read data registered; held between reads
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_r <= '0;
        end else if (rd_hit) begin
            reg_rdata_r <= rd_nxt;
        end
    end

    // receive clock to the mac; lags one cycle, held low while disabled
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_clk_out_r <= 1'b0;
        end else begin
            rx_clk_out_r <= rx_clk_in && !rxclk_off_r;
        end
    end

    // field copies for the termination and timer logic, one cycle behind the fields
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mac_term_sel_r <= '0;
            sleep_sel_r <= PXR_SLEEP_RST;
            lto_sel_r <= PXR_LTO_RST;
        end else begin
            mac_term_sel_r <= cal_r;
            sleep_sel_r <= sleep_r;
            lto_sel_r <= lto_r;
        end
    end

    // downshift request; clearing the enable withdraws it one cycle later, the status stays
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            downshift_r <= 1'b0;
        end else begin
            downshift_r <= ds_stat_r && ds_en_r;
        end
    end

    // reload pulse one cycle after the software reset, only when asked for
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            eeprom_reload_r <= 1'b0;
        end else begin
            eeprom_reload_r <= soft_rst && reload_r;
        end
    end
endmodule : pxr_bank

// >>> src/pxr_pkg.sv
// Summary of operation
// - count good-crc packets, clear on read
// - packet-since-read flag, clears on read
// - two-bit mac termination target select
// - sleep timer one to four seconds
// - link-status timeout one to four seconds
// - receive clock held low when disabled
// - enable auto downshift from gigabit
// - failed attempts before downshift, two to five
// - downshift status bit reads back
// - reload eeprom after software reset when set
// - access trigger starts one access, self-clears
// - direction bit, one is read, resets one
// - ready bit shows interface can accept command
// - eleven-bit eeprom byte address, resets zero
// - fetched byte shown in data bits 15:8
// - write byte held in data bits 7:0
package pxr_pkg;
    localparam logic [4:0] PXR_PAGE_EXT = 5'h01;
    localparam logic [4:0] PXR_OFS_CRC = 5'h12;
    localparam logic [4:0] PXR_OFS_CAL = 5'h13;
    localparam logic [4:0] PXR_OFS_PSL = 5'h14;
    localparam logic [4:0] PXR_OFS_EEC = 5'h15;
    localparam logic [4:0] PXR_OFS_EED = 5'h16;
    localparam int PXR_CRC_FLAG_BIT = 15;
    localparam int PXR_CAL_POS = 14;
    localparam int PXR_SLEEP_POS = 13;
    localparam int PXR_LTO_POS = 9;
    localparam int PXR_RXCLK_OFF_BIT = 5;
    localparam int PXR_DS_EN_BIT = 4;
    localparam int PXR_DS_CNT_POS = 2;
    localparam int PXR_DS_STAT_BIT = 1;
    localparam int PXR_RELOAD_BIT = 14;
    localparam int PXR_GO_BIT = 13;
    localparam int PXR_DIR_BIT = 12;
    localparam int PXR_RDY_BIT = 11;
    localparam int PXR_RDATA_POS = 8;
    localparam logic [1:0] PXR_SLEEP_RST = 2'h1;
    localparam logic [1:0] PXR_LTO_RST = 2'h1;
    localparam logic [1:0] PXR_DS_CNT_RST = 2'h1;
    localparam logic [1:0] PXR_DS_BASE = 2'h2;
    localparam logic PXR_DIR_RST = 1'b1;
    typedef struct packed {
        logic req;    // start; one cycle from the bank, held until done toward the agent
        logic rd;     // 1 read, 0 write
        logic [10:0] addr;
        logic [7:0] wdata;
    } pxr_ee_cmd_t;
endpackage : pxr_pkg

// >>> src/pxr_ee_port.sv
`timescale 1ns/10ps
// eeprom access sequencer: hands one command to the external agent and waits
module pxr_ee_port
    import pxr_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic rst_b, // async reset, active low
    input wire pxr_ee_cmd_t cmd, // command from register bank
    output logic ready_r, // idle, may accept
    output logic [7:0] rdata_r, // last byte read
    output pxr_ee_cmd_t ee_cmd_r, // request to eeprom agent
    input wire logic ee_done, // agent finished access
    input wire logic [7:0] ee_rdata // byte from agent
);
    typedef enum logic [1:0] {PXR_IDLE = 2'b01, PXR_BUSY = 2'b10} pxr_st_t;
    pxr_st_t st_r;

    // request held until the agent answers, so a slow agent is never missed
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= PXR_IDLE;
            ee_cmd_r <= '0;
        end else begin
            unique case (st_r)
                PXR_IDLE: if (cmd.req) begin
                    st_r <= PXR_BUSY;
                    ee_cmd_r <= cmd;
                end
                PXR_BUSY: if (ee_done) begin
                    st_r <= PXR_IDLE;
                    ee_cmd_r.req <= 1'b0;
                end
                default: st_r <= PXR_IDLE;
            endcase
        end
    end

    // ready drops the cycle after the start and returns after done
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ready_r <= 1'b1;
        end else begin
            ready_r <= (st_r == PXR_IDLE) ? !cmd.req : ee_done;
        end
    end

    // captured byte only replaced by a finished read
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= '0;
        end else if (st_r == PXR_BUSY && ee_done && ee_cmd_r.rd) begin
            rdata_r <= ee_rdata;
        end
    end
endmodule : pxr_ee_port

// >>> testbench/pxr_bank_properties.sv
`timescale 1ns/10ps
// watches the management port, receive clock and eeprom request of the bank
module pxr_bank_properties
    import pxr_pkg::*;
(
    input wire logic clk_sys, // clock
    input wire logic rst_b, // hw reset
    input wire logic soft_rst, // sw reset
    input wire logic [4:0] page_sel, // page
    input wire logic [4:0] reg_addr, // register
    input wire logic reg_wr, // write
    input wire logic reg_rd, // read
    input wire logic [15:0] reg_wdata, // wdata
    input wire logic [15:0] reg_rdata_r, // rdata
    input wire logic crc_good_pkt, // packet
    input wire logic rx_clk_in, // clock in
    input wire logic rx_clk_out_r, // clock out
    input wire logic [1:0] mac_term_sel_r, // termination
    input wire logic eeprom_reload_r, // reload
    input wire pxr_ee_cmd_t ee_cmd_r, // request
    input wire logic ee_done // done
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic ext;
    logic trig;
    logic crc_rd;
    // shared decodes; a trigger right after another is left out, the first one owns the port
    assign ext = (page_sel == PXR_PAGE_EXT);
    assign trig = ext && reg_wr && reg_addr == PXR_OFS_EEC && reg_wdata[PXR_GO_BIT];
    assign crc_rd = ext && reg_rd && reg_addr == PXR_OFS_CRC && !crc_good_pkt;
    rxclk_gate_a: assert property (rx_clk_out_r |-> $past(rx_clk_in))
        else $error("receive clock out high without clock in");
    clear_read_a: assert property (
        crc_rd ##2 (crc_rd && !$past(crc_good_pkt)) |=> reg_rdata_r == 16'h0000)
        else $error("second good-crc read not zero");
    page_off_a: assert property (!ext && reg_rd && !soft_rst |=> $stable(reg_rdata_r))
        else $error("read on main page changed read data");
    term_write_a: assert property (
        ext && reg_wr && reg_addr == PXR_OFS_CAL |-> ##2 mac_term_sel_r == $past(reg_wdata[15:14], 2))
        else $error("termination select does not follow write");
    req_hold_a: assert property (ee_cmd_r.req && !ee_done |=> ee_cmd_r.req && $stable(ee_cmd_r))
        else $error("eeprom request changed before done");
    req_drop_a: assert property (ee_cmd_r.req && ee_done |=> !ee_cmd_r.req)
        else $error("eeprom request kept after done");
    launch_a: assert property (
        trig && !ee_cmd_r.req && !$past(trig) |-> ##2 ee_cmd_r.req &&
        ee_cmd_r.rd == $past(reg_wdata[PXR_DIR_BIT], 2) && ee_cmd_r.addr == $past(reg_wdata[10:0], 2))
        else $error("eeprom access not launched as written");
    reload_pulse_a: assert property (eeprom_reload_r |-> $past(soft_rst) ##1 !eeprom_reload_r)
        else $error("reload pulse without software reset");
    cover property (trig ##[2:20] ee_done);
    cover property (eeprom_reload_r);
    cover property (crc_rd ##1 reg_rdata_r[PXR_CRC_FLAG_BIT]);
endmodule : pxr_bank_properties

bind pxr_bank pxr_bank_properties u_props (.clk_sys, .rst_b, .soft_rst, .page_sel, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_r, .crc_good_pkt, .rx_clk_in, .rx_clk_out_r,
    .mac_term_sel_r, .eeprom_reload_r, .ee_cmd_r, .ee_done);

// >>> testbench/pxr_ee_model.sv
`timescale 1ns/10ps
// configuration eeprom agent: answers each request lat plus one cycles after it is raised
module pxr_ee_model
    import pxr_pkg::*;
(
    input wire logic clk_sys, // clock
    input wire logic rst_b, // reset
    input wire pxr_ee_cmd_t cmd, // request
    input wire logic [3:0] lat, // wait cycles
    output logic done, // finished pulse
    output logic [7:0] rdata // byte read
);
    logic [7:0] mem [0:2047];
    logic [3:0] cnt_r;
    // preset contents so every byte is predictable
    initial for (int i = 0; i < 2048; i++) mem[i] = i[7:0] ^ 8'h5a;
    // data toggles while not valid so a stale byte is never mistaken for an answer
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 4'h0;
            done <= 1'b0;
            rdata <= 8'h00;
        end else begin
            done <= 1'b0;
            rdata <= ~rdata;
            if (cmd.req && !done) begin
                cnt_r <= cnt_r + 4'h1;
                if (cnt_r == lat) begin
                    cnt_r <= 4'h0;
                    done <= 1'b1;
                    if (cmd.rd) rdata <= mem[cmd.addr];
                    else mem[cmd.addr] <= cmd.wdata;
                end
            end
        end
    end
endmodule : pxr_ee_model

// >>> testbench/testbench.sv
`timescale 1ns/10ps
// register-level tests of the extended bank with an eeprom agent attached
module testbench
    import pxr_pkg::*;
();
    logic clk_sys = 1'b0, rst_b = 1'b0, soft_rst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic crc_good_pkt = 1'b0, neg_fail_1g = 1'b0, rx_clk_in = 1'b0, ds_en_strap = 1'b1;
    logic [4:0] page_sel = 5'h01, reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata_r, v;
    logic rx_clk_out_r, downshift_r, eeprom_reload_r, ee_done;
    logic [1:0] mac_term_sel_r, sleep_sel_r, lto_sel_r, cal_strap = 2'h2;
    logic [7:0] ee_rdata;
    logic [3:0] lat = 4'h2;
    pxr_ee_cmd_t ee_cmd_r;
    int n_fail = 0, num_checks = 0, cycles = 0;
    always #5 clk_sys = ~clk_sys;
    // internal receive clock at half the system rate
    always @(negedge clk_sys) rx_clk_in <= ~rx_clk_in;
    pxr_bank DUT (.clk_sys, .rst_b, .soft_rst, .page_sel, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata_r, .crc_good_pkt, .neg_fail_1g, .link_up_1g(1'b0), .rx_clk_in, .rx_clk_out_r,
        .mac_term_sel_r, .sleep_sel_r, .lto_sel_r, .downshift_r, .eeprom_reload_r, .ee_cmd_r,
        .ee_done, .ee_rdata, .cal_strap, .ds_en_strap);
    pxr_ee_model u_ee (.clk_sys, .rst_b, .cmd(ee_cmd_r), .lat, .done(ee_done), .rdata(ee_rdata));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    // the whole run needs about 33k cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] got);
        num_checks++;
        if (got !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, e, got);
        end
    endtask : chk
    // strobes last one cycle, then one idle cycle so calls never collide
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        @(negedge clk_sys);
    endtask : wr
    task automatic rd(input logic [4:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        v = reg_rdata_r;
        @(negedge clk_sys);
    endtask : rd
    task automatic rc(input logic [4:0] a, input logic [15:0] e, input string n);
        rd(a);
        chk(n, e, v);
    endtask : rc
    task automatic pulse(ref logic s, input int n);
        repeat (n) begin
            s = 1'b1;
            @(negedge clk_sys);
            s = 1'b0;
            @(negedge clk_sys);
        end
    endtask : pulse
    // polls the ready flag, bounded
    task automatic ee_wait;
        for (int i = 0; i < 40; i++) begin
            rd(PXR_OFS_EEC);
            if (v[PXR_RDY_BIT] === 1'b1) break;
        end
    endtask : ee_wait
    initial begin
        repeat (3) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (2) @(negedge clk_sys);
        rc(PXR_OFS_CRC, 16'h0000, "crc idle");
        rc(PXR_OFS_CAL, 16'h8000, "cal strap");
        rc(PXR_OFS_PSL, 16'h2214, "psl reset");
        rc(PXR_OFS_EEC, 16'h1800, "eec reset");
        rc(PXR_OFS_EED, 16'h0000, "eed reset");
        $display("test reset values done");
        pulse(crc_good_pkt, 3);
        rc(PXR_OFS_CRC, 16'h8003, "crc three");
        rc(PXR_OFS_CRC, 16'h0000, "crc cleared");
        pulse(crc_good_pkt, 16385);
        rc(PXR_OFS_CRC, 16'h8001, "crc wrap");
        $display("test good-crc counter done");
        page_sel = 5'h00;
        wr(PXR_OFS_CAL, 16'h4000);
        rd(PXR_OFS_CAL);
        chk("rd other page", 16'h8001, v);
        page_sel = 5'h01;
        rc(PXR_OFS_CAL, 16'h8000, "cal other page");
        for (int i = 0; i < 4; i++) begin
            wr(PXR_OFS_CAL, {i[1:0], 14'h3fff});
            rc(PXR_OFS_CAL, {i[1:0], 14'h0}, "cal code");
            chk("term sel", {14'h0, i[1:0]}, {14'h0, mac_term_sel_r});
        end
        $display("test page and termination done");
        wr(PXR_OFS_PSL, 16'hffff);
        rc(PXR_OFS_PSL, 16'h663c, "psl all ones");
        chk("sleep sel", 16'h3, {14'h0, sleep_sel_r});
        chk("lto sel", 16'h3, {14'h0, lto_sel_r});
        chk("rx clk held", 16'h0, {15'h0, rx_clk_out_r});
        wr(PXR_OFS_PSL, 16'h0010);
        v[0] = rx_clk_out_r;
        @(negedge clk_sys);
        chk("rx clk runs", {15'h0, ~v[0]}, {15'h0, rx_clk_out_r});
        pulse(neg_fail_1g, 1);
        rc(PXR_OFS_PSL, 16'h0010, "one fail");
        pulse(neg_fail_1g, 1);
        rc(PXR_OFS_PSL, 16'h0012, "two fails");
        chk("downshift", 16'h1, {15'h0, downshift_r});
        $display("test power and downshift done");
        wr(PXR_OFS_PSL, 16'h0030);
        wr(PXR_OFS_EEC, 16'h4000);
        soft_rst = 1'b1;
        @(negedge clk_sys);
        soft_rst = 1'b0;
        chk("reload", 16'h1, {15'h0, eeprom_reload_r});
        rc(PXR_OFS_PSL, 16'h0210, "psl soft reset");
        rc(PXR_OFS_EEC, 16'h5800, "eec soft reset");
        rc(PXR_OFS_CAL, 16'hc000, "cal soft reset");
        $display("test software reset done");
        wr(PXR_OFS_PSL, 16'h001c);
        pulse(neg_fail_1g, 4);
        rc(PXR_OFS_PSL, 16'h001c, "four fails");
        pulse(neg_fail_1g, 1);
        rc(PXR_OFS_PSL, 16'h001e, "five fails");
        chk("downshift five", 16'h1, {15'h0, downshift_r});
        wr(PXR_OFS_PSL, 16'h000c);
        rc(PXR_OFS_PSL, 16'h000e, "enable off");
        chk("no downshift", 16'h0, {15'h0, downshift_r});
        $display("test downshift threshold done");
        wr(PXR_OFS_EED, 16'hffa7);
        rc(PXR_OFS_EED, 16'h00a7, "write byte");
        wr(PXR_OFS_EEC, 16'h2123);
        ee_wait();
        chk("write done", 16'h0923, v);
        lat = 4'h8;
        wr(PXR_OFS_EEC, 16'h3123);
        rd(PXR_OFS_EEC);
        chk("busy", 16'h0, {15'h0, v[PXR_RDY_BIT]});
        wr(PXR_OFS_EEC, 16'h27ff);
        ee_wait();
        chk("read done", 16'h1923, v);
        rc(PXR_OFS_EED, 16'ha7a7, "read back");
        lat = 4'h0;
        wr(PXR_OFS_EEC, 16'h37ff);
        ee_wait();
        rc(PXR_OFS_EED, 16'ha5a7, "read top");
        $display("test eeprom access done");
        wrap_up();
    end
endmodule : testbench
